// ===== hdl/stdtm_core.sv
// Standard timer core with classic Wishbone register access.
//
// Summary of operation
// - Sixteen-bit free-running up-counter advanced by the selected clock.
// - Period comparator is eight bits, compared with counter top byte.
// - Duty comparator holds sixteen bits, compared with the whole counter.
// - Separate interrupt sources for duty match and period match.
// - Compare match may clear the counter and change the output pin.
// - Software cannot load the counter; counter-on rising clears it.
// - Counter clears on overflow or selected match, raising an interrupt.
// - Three-bit field selects system ratios, high clock, sub clock, external pin.
// - External clock counts on rising or falling pin edge as selected.
// - Single pulse mode uses the external clock pin as trigger.
// - Capture input reacts to rising, falling or both edges.
// - Compare output mode sets, clears or toggles pins on match.
// - Primary and complementary outputs; PWM appears on the primary pin.
// - Low bytes reach software only through one shared eight-bit buffer.
// - Low write fills buffer; high write stores high and copies buffer.
// - High read returns high, latches low into buffer; low read returns buffer.
// - Counter pair is read-only; duty pair is read and write.
// - Five modes: compare, timer, capture, single pulse, PWM.
// - Mode field 00 compare, 01 capture, 10 PWM or pulse, 11 timer.
// - Pause holds the counter; clearing pause resumes from held value.
// - In compare and timer modes, clear select set clears on duty match, else period match or overflow.
`timescale 1ns/1ps
module stdtm_core
	import stdtm_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CLK_EN,
	input wire logic SUB_CLOCK,
	input wire logic EXTERNAL_CLOCK_PIN,
	input wire logic CAPTURE_INPUT_PIN,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [2:0] WB_ADR_I,
	input wire logic [7:0] WB_DAT_I,
	input wire logic WB_SEL_I,
	output logic [7:0] WB_DAT_O,
	output logic WB_ACK_O,
	output logic PRIMARY_OUTPUT_PIN,
	output logic COMPLEMENTARY_OUTPUT_PIN,
	output logic DUTY_MATCH_IRQ,
	output logic PERIOD_MATCH_IRQ
);
	import stdtm_pkg::*;

	logic [7:0] ctrl_clock_run;
	logic [7:0] ctrl_mode_output;
	logic [15:0] counter;
	logic [15:0] duty_compare_value;
	logic [7:0] period_compare_value;
	logic [7:0] low_buffer;
	logic [5:0] div_cnt;
	logic [2:0] ext_sync;
	logic [2:0] cap_sync;
	logic [2:0] sub_sync;
	logic on_prev;
	logic out_level;
	logic pulse_run;

	logic counter_on;
	logic counter_pause;
	logic [2:0] clock_source_select;
	logic [1:0] operating_mode_select;
	logic [1:0] pin_function_select;
	logic init_level;
	logic polarity;
	logic swap_roles;
	logic clear_select;
	logic tick;
	logic duty_match;
	logic period_match;
	logic overflow;
	logic clear_cnt;
	logic on_rise;
	logic ext_rise;
	logic ext_fall;
	logic cap_event;
	logic bus_req;
	logic [15:0] pwm_duty;

	assign counter_on = ctrl_clock_run[POS_ON];
	assign counter_pause = ctrl_clock_run[POS_PAUSE];
	assign clock_source_select = ctrl_clock_run[POS_CLKSEL +: 3];
	assign operating_mode_select = ctrl_mode_output[POS_MODE +: 2];
	assign pin_function_select = ctrl_mode_output[POS_PINFN +: 2];
	assign init_level = ctrl_mode_output[POS_INITLVL];
	assign polarity = ctrl_mode_output[POS_POLARITY];
	assign swap_roles = ctrl_mode_output[POS_SWAP];
	assign clear_select = ctrl_mode_output[POS_CLRSEL];
	assign on_rise = counter_on & ~on_prev;
	assign ext_rise = ext_sync[1] & ~ext_sync[2];
	assign ext_fall = ~ext_sync[1] & ext_sync[2];
	assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;

	// Period comparison value as a full count; zero stands for a full wrap.
	function automatic logic [15:0] period_span(input logic [7:0] p);
		period_span = {p, 8'h00};
	endfunction

	// Clock source selection, with the pin edges seen through synchronisers.
	always_comb
	begin
		case (clock_source_select)
			CK_SYS_DIV4: tick = (div_cnt[1:0] == 2'h3);
			CK_SYS: tick = 1'b1;
			CK_HIGH_DIV16: tick = (div_cnt[3:0] == 4'hF);
			CK_HIGH_DIV64: tick = (div_cnt == DIV_LAST);
			CK_EXT_RISE: tick = ext_rise;
			CK_EXT_FALL: tick = ext_fall;
			default: tick = sub_sync[1] & ~sub_sync[2];
		endcase
	end

	assign duty_match = tick & (counter == duty_compare_value - 16'h0001) & counter_on
		& ~counter_pause;
	assign period_match = tick & counter_on & ~counter_pause & (period_compare_value != 8'h00)
		& (counter == period_span(period_compare_value) - 16'h0001);
	assign overflow = tick & counter_on & ~counter_pause & (counter == 16'hFFFF);

	always_comb
	begin
		pwm_duty = swap_roles ? period_span(period_compare_value) : duty_compare_value;
		clear_cnt = 1'b0;
		case (operating_mode_select)
			MODE_COMPARE, MODE_TIMER: clear_cnt = clear_select ? duty_match : period_match;
			MODE_PWM: clear_cnt = swap_roles ? duty_match : period_match;
			default: clear_cnt = 1'b0;
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			div_cnt <= 6'h00;
		else if (CLK_EN)
			div_cnt <= div_cnt + 6'h01;
	end

	// Pin inputs pass three flops; only stage two and later feed edge logic.
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ext_sync <= 3'h0;
			cap_sync <= 3'h0;
			sub_sync <= 3'h0;
		end
		else if (CLK_EN)
		begin
			ext_sync <= {ext_sync[1:0], EXTERNAL_CLOCK_PIN};
			cap_sync <= {cap_sync[1:0], CAPTURE_INPUT_PIN};
			sub_sync <= {sub_sync[1:0], SUB_CLOCK};
		end
	end

	always_comb
	begin
		case (pin_function_select)
			2'h0: cap_event = cap_sync[1] & ~cap_sync[2];
			2'h1: cap_event = ~cap_sync[1] & cap_sync[2];
			2'h2: cap_event = cap_sync[1] ^ cap_sync[2];
			default: cap_event = 1'b0;
		endcase
	end

	// Counter; software has no load path, only the counter-on rising clear.
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			counter <= RST_WORD;
			on_prev <= 1'b0;
		end
		else if (CLK_EN)
		begin
			on_prev <= counter_on;
			if (on_rise)
				counter <= RST_WORD;
			else if (clear_cnt)
				counter <= RST_WORD;
			else if (counter_on && !counter_pause && tick)
				counter <= counter + 16'h0001;
		end
	end

	// Output level, interpreted per mode.
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			out_level <= 1'b0;
			pulse_run <= 1'b0;
		end
		else if (CLK_EN)
		begin
			case (operating_mode_select)
				MODE_COMPARE:
				begin
					if (on_rise)
						out_level <= init_level;
					else if (duty_match)
						case (pin_function_select)
							2'h1: out_level <= 1'b0;
							2'h2: out_level <= 1'b1;
							2'h3: out_level <= ~out_level;
							default: out_level <= out_level;
						endcase
				end
				MODE_PWM:
				begin
					case (pin_function_select)
						2'h0: pulse_run <= 1'b0;
						2'h1: pulse_run <= 1'b1;
						2'h2: pulse_run <= counter_on && (counter < pwm_duty) && !clear_cnt;
						default:
						begin
							if ((ext_rise || on_rise) && counter_on)
								pulse_run <= 1'b1;
							else if (duty_match || !counter_on)
								pulse_run <= 1'b0;
						end
					endcase
					out_level <= pulse_run ? init_level : ~init_level;
				end
				default: out_level <= out_level;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			PRIMARY_OUTPUT_PIN <= 1'b0;
			COMPLEMENTARY_OUTPUT_PIN <= 1'b1;
		end
		else if (CLK_EN)
		begin
			PRIMARY_OUTPUT_PIN <= out_level ^ polarity;
			COMPLEMENTARY_OUTPUT_PIN <= ~(out_level ^ polarity);
		end
	end

	// The flag flops drive the request outputs directly, saving a cycle of latency.
	// A new match wins over a software clear in the same cycle.
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			DUTY_MATCH_IRQ <= 1'b0;
			PERIOD_MATCH_IRQ <= 1'b0;
		end
		else if (CLK_EN)
		begin
			if (duty_match || (operating_mode_select == MODE_CAPTURE && cap_event))
				DUTY_MATCH_IRQ <= 1'b1;
			else if (bus_req && WB_WE_I && WB_SEL_I && WB_ADR_I == ADR_FLAGS && WB_DAT_I[0])
				DUTY_MATCH_IRQ <= 1'b0;
			if (period_match || overflow)
				PERIOD_MATCH_IRQ <= 1'b1;
			else if (bus_req && WB_WE_I && WB_SEL_I && WB_ADR_I == ADR_FLAGS && WB_DAT_I[1])
				PERIOD_MATCH_IRQ <= 1'b0;
		end
	end

	// Register writes. Capture mode loads the duty register from the counter.
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ctrl_clock_run <= RST_BYTE;
			ctrl_mode_output <= RST_BYTE;
			duty_compare_value <= RST_WORD;
			period_compare_value <= RST_BYTE;
			low_buffer <= RST_BYTE;
		end
		else if (CLK_EN)
		begin
			if (operating_mode_select == MODE_CAPTURE && cap_event)
				duty_compare_value <= counter;
			if (bus_req && WB_SEL_I && WB_WE_I)
			begin
				case (WB_ADR_I)
					ADR_CTRL_CLOCK_RUN: ctrl_clock_run <= WB_DAT_I & MASK_CTRL_CLOCK_RUN;
					ADR_CTRL_MODE_OUTPUT: ctrl_mode_output <= WB_DAT_I;
					ADR_DUTY_LOW: low_buffer <= WB_DAT_I;
					ADR_DUTY_HIGH: duty_compare_value <= {WB_DAT_I, low_buffer};
					ADR_PERIOD: period_compare_value <= WB_DAT_I;
					default: low_buffer <= low_buffer;
				endcase
			end
			else if (bus_req && WB_SEL_I)
			begin
				if (WB_ADR_I == ADR_COUNT_HIGH)
					low_buffer <= counter[7:0];
				else if (WB_ADR_I == ADR_DUTY_HIGH)
					low_buffer <= duty_compare_value[7:0];
			end
		end
	end

	// Single-wait Wishbone slave: ack one cycle after the request is seen.
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= RST_BYTE;
		end
		else if (CLK_EN)
		begin
			WB_ACK_O <= bus_req;
			if (bus_req && !WB_WE_I)
			begin
				case (WB_ADR_I)
					ADR_CTRL_CLOCK_RUN: WB_DAT_O <= ctrl_clock_run;
					ADR_CTRL_MODE_OUTPUT: WB_DAT_O <= ctrl_mode_output;
					ADR_COUNT_LOW, ADR_DUTY_LOW: WB_DAT_O <= low_buffer;
					ADR_COUNT_HIGH: WB_DAT_O <= counter[15:8];
					ADR_DUTY_HIGH: WB_DAT_O <= duty_compare_value[15:8];
					ADR_PERIOD: WB_DAT_O <= period_compare_value;
					default: WB_DAT_O <= {6'h00, PERIOD_MATCH_IRQ, DUTY_MATCH_IRQ};
				endcase
			end
		end
	end
endmodule

// ===== hdl/stdtm_pkg.sv
// Package with register map, field positions and encodings of the standard timer core.
package stdtm_pkg;
	localparam logic [2:0] ADR_CTRL_CLOCK_RUN = 3'h0;
	localparam logic [2:0] ADR_CTRL_MODE_OUTPUT = 3'h1;
	localparam logic [2:0] ADR_COUNT_LOW = 3'h2;
	localparam logic [2:0] ADR_COUNT_HIGH = 3'h3;
	localparam logic [2:0] ADR_DUTY_LOW = 3'h4;
	localparam logic [2:0] ADR_DUTY_HIGH = 3'h5;
	localparam logic [2:0] ADR_PERIOD = 3'h6;
	localparam logic [2:0] ADR_FLAGS = 3'h7;
	localparam int POS_PAUSE = 7;
	localparam int POS_CLKSEL = 4;
	localparam int POS_ON = 3;
	localparam int POS_MODE = 6;
	localparam int POS_PINFN = 4;
	localparam int POS_INITLVL = 3;
	localparam int POS_POLARITY = 2;
	localparam int POS_SWAP = 1;
	localparam int POS_CLRSEL = 0;
	localparam logic [7:0] MASK_CTRL_CLOCK_RUN = 8'hF8;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [1:0] MODE_COMPARE = 2'h0;
	localparam logic [1:0] MODE_CAPTURE = 2'h1;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TIMER = 2'h3;
	localparam logic [2:0] CK_SYS_DIV4 = 3'h0;
	localparam logic [2:0] CK_SYS = 3'h1;
	localparam logic [2:0] CK_HIGH_DIV16 = 3'h2;
	localparam logic [2:0] CK_HIGH_DIV64 = 3'h3;
	localparam logic [2:0] CK_EXT_RISE = 3'h6;
	localparam logic [2:0] CK_EXT_FALL = 3'h7;
	localparam logic [5:0] DIV_LAST = 6'h3F;
endpackage

// ===== sim/stdtm_core_asserts.sv
// Port-level assertions for the standard timer core.
`timescale 1ns/1ps
module stdtm_core_asserts
	import stdtm_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CLK_EN,
	input wire logic SUB_CLOCK,
	input wire logic EXTERNAL_CLOCK_PIN,
	input wire logic CAPTURE_INPUT_PIN,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [2:0] WB_ADR_I,
	input wire logic [7:0] WB_DAT_I,
	input wire logic WB_SEL_I,
	input wire logic [7:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	input wire logic PRIMARY_OUTPUT_PIN,
	input wire logic COMPLEMENTARY_OUTPUT_PIN,
	input wire logic DUTY_MATCH_IRQ,
	input wire logic PERIOD_MATCH_IRQ
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	logic take;
	logic clr_d;
	logic clr_p;
	assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O && CLK_EN;
	assign clr_d = take && WB_WE_I && WB_SEL_I && WB_ADR_I == ADR_FLAGS && WB_DAT_I[0];
	assign clr_p = take && WB_WE_I && WB_SEL_I && WB_ADR_I == ADR_FLAGS && WB_DAT_I[1];
	a_ack_one_pulse: assert property (WB_ACK_O && CLK_EN |=> !WB_ACK_O)
		else $error("ack held past one cycle");
	a_req_gets_ack: assert property (take |=> WB_ACK_O)
		else $error("request not acknowledged");
	a_ack_has_cause: assert property ($rose(WB_ACK_O) |-> $past(take))
		else $error("ack without request");
	a_rdata_holds: assert property (!(take && !WB_WE_I) |=> $stable(WB_DAT_O))
		else $error("read data changed without read");
	a_pins_complement: assert property (COMPLEMENTARY_OUTPUT_PIN != PRIMARY_OUTPUT_PIN)
		else $error("output pins not complementary");
	a_duty_flag_sticky: assert property ($fell(DUTY_MATCH_IRQ) |->
		$past(clr_d) || $past(clr_d, 2) || $past(clr_d, 3)) else $error("duty flag lost");
	a_period_flag_sticky: assert property ($fell(PERIOD_MATCH_IRQ) |->
		$past(clr_p) || $past(clr_p, 2) || $past(clr_p, 3)) else $error("period flag lost");
	a_frozen_when_off: assert property (!CLK_EN |=> $stable(WB_ACK_O) &&
		$stable(PRIMARY_OUTPUT_PIN) && $stable(DUTY_MATCH_IRQ)) else $error("state moved");
	c_duty: cover property (DUTY_MATCH_IRQ);
	c_period: cover property (PERIOD_MATCH_IRQ);
	c_write: cover property (take && WB_WE_I);
endmodule

// ===== sim/tb_stdtm_core.sv
// Self-checking bench for the standard timer core.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_stdtm_core;
	import stdtm_pkg::*;
	logic CLK = 1'b0, RST_N = 1'b0, CLK_EN = 1'b1, SUB_CLOCK = 1'b0;
	logic EXTERNAL_CLOCK_PIN = 1'b0, CAPTURE_INPUT_PIN = 1'b0;
	logic WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0, WB_SEL_I = 1'b1;
	logic [2:0] WB_ADR_I = 3'h0;
	logic [7:0] WB_DAT_I = 8'h00;
	logic [7:0] WB_DAT_O, q;
	logic WB_ACK_O, PRIMARY_OUTPUT_PIN, COMPLEMENTARY_OUTPUT_PIN, DUTY_MATCH_IRQ, PERIOD_MATCH_IRQ;
	logic [15:0] v;
	int mismatches = 0;
	int compares = 0;
	int n;
	stdtm_core dut_u (.CLK(CLK), .RST_N(RST_N), .CLK_EN(CLK_EN), .SUB_CLOCK(SUB_CLOCK),
		.EXTERNAL_CLOCK_PIN(EXTERNAL_CLOCK_PIN), .CAPTURE_INPUT_PIN(CAPTURE_INPUT_PIN),
		.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
		.WB_DAT_I(WB_DAT_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
		.PRIMARY_OUTPUT_PIN(PRIMARY_OUTPUT_PIN), .COMPLEMENTARY_OUTPUT_PIN(COMPLEMENTARY_OUTPUT_PIN),
		.DUTY_MATCH_IRQ(DUTY_MATCH_IRQ), .PERIOD_MATCH_IRQ(PERIOD_MATCH_IRQ));
	task automatic summarize();
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// One classic cycle; the request stands until ack is sampled high.
	task automatic wb(input logic we, input logic [2:0] a, input logic [7:0] d);
		n = 0;
		WB_CYC_I <= 1'b1;
		WB_STB_I <= 1'b1;
		WB_WE_I <= we;
		WB_ADR_I <= a;
		WB_DAT_I <= d;
		@(posedge CLK);
		while (WB_ACK_O !== 1'b1 && n < 50)
		begin
			@(posedge CLK);
			n++;
		end
		`CHK("ack", 1'b1, WB_ACK_O)
		q = WB_DAT_O;
		WB_CYC_I <= 1'b0;
		WB_STB_I <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic rdcnt();
		wb(1'b0, ADR_COUNT_HIGH, 8'h00);
		v[15:8] = q;
		wb(1'b0, ADR_COUNT_LOW, 8'h00);
		v[7:0] = q;
	endtask
	task automatic ctl0(input logic pau, input logic [2:0] ck, input logic on);
		wb(1'b1, ADR_CTRL_CLOCK_RUN, {pau, ck, on, 3'h0});
	endtask
	task automatic wait_irq(input logic per, input int lim);
		n = 0;
		while ((per ? PERIOD_MATCH_IRQ : DUTY_MATCH_IRQ) !== 1'b1 && n < lim)
		begin
			@(posedge CLK);
			n++;
		end
	endtask
	task automatic t_reset();
		logic [2:0] ord [7] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h5, 3'h4, 3'h6};
		`CHK("pins", 4'b0100, {PRIMARY_OUTPUT_PIN, COMPLEMENTARY_OUTPUT_PIN, DUTY_MATCH_IRQ, PERIOD_MATCH_IRQ})
		foreach (ord[i])
		begin
			wb(1'b0, ord[i], 8'h00);
			`CHK("reset value", RST_BYTE, q)
		end
	endtask
	task automatic t_buffer();
		wb(1'b1, ADR_DUTY_LOW, 8'h34);
		wb(1'b1, ADR_DUTY_HIGH, 8'h12);
		WB_SEL_I <= 1'b0;
		wb(1'b1, ADR_DUTY_HIGH, 8'hFF);
		WB_SEL_I <= 1'b1;
		wb(1'b1, ADR_COUNT_HIGH, 8'hAB);
		wb(1'b0, ADR_DUTY_HIGH, 8'h00);
		`CHK("duty high", 8'h12, q)
		wb(1'b0, ADR_DUTY_LOW, 8'h00);
		`CHK("duty low", 8'h34, q)
		rdcnt();
		`CHK("count read only", 16'h0000, v)
	endtask
	task automatic t_count();
		logic [2:0] cks [4] = '{CK_SYS, CK_SYS_DIV4, CK_HIGH_DIV16, CK_HIGH_DIV64};
		int dv [4] = '{1, 4, 16, 64};
		logic [15:0] hold;
		foreach (cks[i])
		begin
			ctl0(1'b0, cks[i], 1'b0);
			ctl0(1'b0, cks[i], 1'b1);
			repeat (400) @(posedge CLK);
			ctl0(1'b1, cks[i], 1'b1);
			rdcnt();
			`CHK("rate", 1'b1, v + 2 >= 400 / dv[i] && v <= 400 / dv[i] + 8)
		end
		hold = v;
		CLK_EN <= 1'b0;
		repeat (10) @(posedge CLK);
		CLK_EN <= 1'b1;
		rdcnt();
		`CHK("pause holds", hold, v)
		ctl0(1'b0, CK_SYS, 1'b0);
		ctl0(1'b1, CK_SYS, 1'b1);
		rdcnt();
		`CHK("on clears", 16'h0000, v)
	endtask
	task automatic t_duty();
		wb(1'b1, ADR_DUTY_LOW, 8'h40);
		wb(1'b1, ADR_DUTY_HIGH, 8'h00);
		wb(1'b1, ADR_CTRL_MODE_OUTPUT, {MODE_COMPARE, 2'b11, 4'b0001});
		ctl0(1'b0, CK_SYS, 1'b1);
		wait_irq(1'b0, 200);
		@(posedge CLK);
		`CHK("duty irq", 1'b1, DUTY_MATCH_IRQ && n >= 48)
		`CHK("pin toggled", 1'b1, PRIMARY_OUTPUT_PIN)
		`CHK("period quiet", 1'b0, PERIOD_MATCH_IRQ)
		ctl0(1'b1, CK_SYS, 1'b1);
		rdcnt();
		`CHK("duty clears", 1'b1, v < 16'h0040)
		repeat (50) @(posedge CLK);
		`CHK("flag stays", 1'b1, DUTY_MATCH_IRQ)
		wb(1'b1, ADR_FLAGS, 8'h01);
		repeat (3) @(posedge CLK);
		`CHK("flag cleared", 1'b0, DUTY_MATCH_IRQ)
	endtask
	task automatic t_period();
		ctl0(1'b0, CK_SYS, 1'b0);
		wb(1'b1, ADR_CTRL_MODE_OUTPUT, 8'h00);
		wb(1'b1, ADR_PERIOD, 8'h01);
		ctl0(1'b0, CK_SYS, 1'b1);
		wait_irq(1'b1, 600);
		`CHK("period time", 1'b1, PERIOD_MATCH_IRQ && n >= 240 && n <= 265)
		ctl0(1'b1, CK_SYS, 1'b1);
		rdcnt();
		`CHK("period clears", 8'h00, v[15:8])
		wb(1'b1, ADR_FLAGS, 8'h03);
		repeat (3) @(posedge CLK);
		`CHK("flags cleared", 2'b00, {DUTY_MATCH_IRQ, PERIOD_MATCH_IRQ})
	endtask
	task automatic t_pwm();
		ctl0(1'b0, CK_SYS, 1'b0);
		wb(1'b1, ADR_CTRL_MODE_OUTPUT, {MODE_PWM, 2'b10, 4'b1000});
		ctl0(1'b0, CK_SYS, 1'b1);
		repeat (300) @(posedge CLK);
		n = 0;
		repeat (256)
		begin
			@(posedge CLK);
			n += PRIMARY_OUTPUT_PIN;
		end
		`CHK("pwm high count", 64, n)
		wb(1'b1, ADR_CTRL_MODE_OUTPUT, {MODE_PWM, 2'b11, 4'b1000});
		wb(1'b1, ADR_FLAGS, 8'h01);
		// Trigger just after a duty match, so the pulse has a full period to show.
		wait_irq(1'b0, 300);
		EXTERNAL_CLOCK_PIN <= 1'b1;
		repeat (8) @(posedge CLK);
		`CHK("pulse started", 1'b1, PRIMARY_OUTPUT_PIN)
		EXTERNAL_CLOCK_PIN <= 1'b0;
		repeat (270) @(posedge CLK);
		`CHK("pulse ended", 1'b0, PRIMARY_OUTPUT_PIN)
	endtask
	task automatic t_ext(input logic [2:0] ck);
		wb(1'b1, ADR_CTRL_MODE_OUTPUT, {MODE_TIMER, 6'h00});
		ctl0(1'b0, ck, 1'b0);
		ctl0(1'b0, ck, 1'b1);
		repeat (5)
		begin
			EXTERNAL_CLOCK_PIN <= 1'b1;
			SUB_CLOCK <= 1'b1;
			repeat (4) @(posedge CLK);
			EXTERNAL_CLOCK_PIN <= 1'b0;
			SUB_CLOCK <= 1'b0;
			repeat (4) @(posedge CLK);
		end
		rdcnt();
		`CHK("edge count", 16'h0005, v)
	endtask
	task automatic cap(input logic [1:0] fn, input logic lvl, input logic e);
		wb(1'b1, ADR_CTRL_MODE_OUTPUT, {MODE_CAPTURE, fn, 4'h0});
		wb(1'b1, ADR_FLAGS, 8'h03);
		CAPTURE_INPUT_PIN <= lvl;
		repeat (10) @(posedge CLK);
		`CHK("capture", e, DUTY_MATCH_IRQ)
	endtask
	initial
	begin
		forever #12.5 CLK = ~CLK;
	end
	initial
	begin
		repeat (30000) @(posedge CLK);
		mismatches++;
		summarize();
	end
	initial
	begin
		repeat (8) @(posedge CLK);
		RST_N <= 1'b1;
		@(posedge CLK);
		t_reset();
		t_buffer();
		t_count();
		t_duty();
		t_period();
		t_pwm();
		t_ext(CK_EXT_RISE);
		t_ext(CK_EXT_FALL);
		t_ext(3'h4);
		ctl0(1'b0, CK_SYS, 1'b1);
		cap(2'b00, 1'b1, 1'b1);
		cap(2'b00, 1'b0, 1'b0);
		cap(2'b01, 1'b1, 1'b0);
		cap(2'b01, 1'b0, 1'b1);
		cap(2'b10, 1'b1, 1'b1);
		cap(2'b10, 1'b0, 1'b1);
		cap(2'b11, 1'b1, 1'b0);
		summarize();
	end
endmodule
bind stdtm_core stdtm_core_asserts chk_u (.CLK(CLK), .RST_N(RST_N), .CLK_EN(CLK_EN),
	.SUB_CLOCK(SUB_CLOCK), .EXTERNAL_CLOCK_PIN(EXTERNAL_CLOCK_PIN),
	.CAPTURE_INPUT_PIN(CAPTURE_INPUT_PIN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
	.WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_SEL_I(WB_SEL_I),
	.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .PRIMARY_OUTPUT_PIN(PRIMARY_OUTPUT_PIN),
	.COMPLEMENTARY_OUTPUT_PIN(COMPLEMENTARY_OUTPUT_PIN), .DUTY_MATCH_IRQ(DUTY_MATCH_IRQ),
	.PERIOD_MATCH_IRQ(PERIOD_MATCH_IRQ));
